// File: spi_msp_consts.vh
// Notes on behaviour
// R1: Master data write starts eight-bit shifting.
// R2: Clock stops after byte; done flag sets.
// R3: Done flag with enable raises interrupt.
// R4: Master never drives slave select itself.
// R5: Master frames packet with select low.
// R6: MOSI out, MISO in, same clock pulses.
// R7: Last received byte held in buffer.
// R8: Deselected slave idle, MISO released.
// R9: Slave data load waits for select.
// R10: Slave sets done flag per byte.
// R11: Slave next-byte load keeps received byte.
// R12: No data write until shift completes.
// R13: Read each byte before next completes.
// R14: External SCK at most quarter clock.
// R15: Enabled block overrides pin directions.
// R16: Bit order selectable, LSB or MSB.
// R17: Seven master rates, fastest half clock.
// R18: Done event can wake from idle.
// R19: Power gate must be zero to run.
// R20: Slave select high resets slave logic.
// R21: Select low as input demotes master.
// R22: Data write during transfer flags collision.
// R23: Flag cleared by vector or status-then-data.
// R24: Clock polarity and phase configurable.
// R25: Disabled block never shifts, releases pins.
`ifndef SPI_MSP_CONSTS_VH
`define SPI_MSP_CONSTS_VH

// ----------------------------------------
// Master half-period counts, core cycles
// ----------------------------------------
`define HALF_DIV4      7'h02
`define HALF_DIV16     7'h08
`define HALF_DIV64     7'h20
`define HALF_DIV128    7'h40
`define HALF_DIV2      7'h01
`define HALF_DIV8      7'h04
`define HALF_DIV32     7'h10

// ----------------------------------------
// Frame geometry and reset values
// ----------------------------------------
`define EDGES_LAST     5'h0F
`define BITS_PER_BYTE  4'h8
`define SYNC_LAG       2
`define BYTE_RESET     8'h00
`define FLAG_RESET     1'b0

`endif

// File: pin_sync.v
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
    // Clock and reset
    input  wire       core_clk_in,
    input  wire       rst_n_in,
    // Raw and synchronised pins
    input  wire [3:0] raw_in,
    output wire [3:0] sync_out
);

reg [3:0] meta_r;
reg [3:0] sync_r;

// ----------------------------------------
// Two-stage synchroniser per pin
// ----------------------------------------
genvar i;
generate
    for (i = 0; i < 4; i = i + 1) begin : g_bit
        // First stage feeds only the second stage
        always @(posedge core_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                meta_r[i] <= 1'b0;
                sync_r[i] <= 1'b0;
            end else begin
                meta_r[i] <= raw_in[i];
                sync_r[i] <= meta_r[i];
            end
        end
    end
endgenerate

assign sync_out = sync_r;

endmodule // pin_sync

`default_nettype wire

// File: spi_master_slave_port.v
`timescale 1ns/1ps
`default_nettype none
`include "spi_msp_consts.vh"

module spi_master_slave_port (
    // Clock and reset
    input  wire       core_clk_in,
    input  wire       rst_n_in,
    // Control bits
    input  wire       serial_enable_bit_in,
    input  wire       power_gate_bit_in,
    input  wire       transfer_irq_enable_in,
    input  wire       lsb_first_in,
    input  wire       cpol_in,
    input  wire       cpha_in,
    input  wire [1:0] rate_sel_in,
    input  wire       double_speed_in,
    input  wire       master_wr_in,
    input  wire       master_wr_data_in,
    // Software accesses
    input  wire       data_wr_in,
    input  wire [7:0] data_wr_byte_in,
    input  wire       data_rd_in,
    input  wire       status_rd_in,
    input  wire       irq_ack_in,
    // User pin directions
    input  wire       mosi_dir_in,
    input  wire       sck_dir_in,
    input  wire       miso_dir_in,
    input  wire       ss_dir_in,
    // Serial pins
    input  wire       ss_n_in,
    input  wire       sck_in,
    output wire       sck_out,
    output wire       sck_oe_out,
    input  wire       mosi_in,
    output wire       mosi_out,
    output wire       mosi_oe_out,
    input  wire       miso_in,
    output wire       miso_out,
    output wire       miso_oe_out,
    output wire       pins_override_out,
    // Status
    output wire [7:0] rx_byte_out,
    output wire       transfer_done_flag_out,
    output wire       write_collision_flag_out,
    output wire       master_select_bit_out,
    output wire       busy_out,
    output wire       irq_out,
    output wire       wake_out
);

// ----------------------------------------
// Declarations
// ----------------------------------------
wire [3:0] pin_s;
wire       ss_s;
wire       sck_s;
wire       mosi_s;
wire       miso_s;
reg        master_r;
reg  [6:0] div_r;
reg  [4:0] edge_r;
reg        gen_run_r;
reg        sck_r;
reg        sck_d_r;
reg  [1:0] pipe_r;
reg  [3:0] bit_cnt_r;
reg        first_r;
reg  [7:0] sh_r;
reg  [7:0] sh_nxt;
reg  [7:0] rx_sh_r;
reg  [7:0] rx_buf_r;
reg        tx_bit_r;
reg        flag_r;
reg        write_collision_flag_r;
reg        arm_flag_r;
reg        arm_write_collision_flag_r;
reg        wake_r;
reg  [6:0] half;

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
pin_sync u_pin_sync (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .raw_in      ({ss_n_in, sck_in, mosi_in, miso_in}),
    .sync_out    (pin_s)
);

assign ss_s   = pin_s[3];
assign sck_s  = pin_s[2];
assign mosi_s = pin_s[1];
assign miso_s = pin_s[0];

// ----------------------------------------
// Mode decode
// ----------------------------------------
// Gated off unless enabled and powered
wire active     = serial_enable_bit_in & ~power_gate_bit_in; // [R19] [R25]
wire is_master  = active & master_r;
wire slave_sel  = active & ~master_r & ~ss_s;                // [R8]
// Select pin as input pulled low by another master
wire mode_fault = is_master & ~ss_dir_in & ~ss_s;            // [R21]

// Transfer in flight, including the sample pipeline tail
wire busy_w = gen_run_r | (pipe_r != 2'b00) |
              (slave_sel & (bit_cnt_r != 4'h0));
wire wr_ok  = data_wr_in & ~busy_w;
wire write_collision_flag_set = data_wr_in & busy_w;                         // [R22]
wire start  = wr_ok & is_master & ~mode_fault;               // [R1] [R25]

// ----------------------------------------
// Rate select: seven distinct rates
// ----------------------------------------
always @* begin
    case ({double_speed_in, rate_sel_in})                    // [R17]
        3'b000:  half = `HALF_DIV4;
        3'b001:  half = `HALF_DIV16;
        3'b010:  half = `HALF_DIV64;
        3'b011:  half = `HALF_DIV128;
        3'b100:  half = `HALF_DIV2;
        3'b101:  half = `HALF_DIV8;
        3'b110:  half = `HALF_DIV32;
        default: half = `HALF_DIV64;
    endcase
end

// ----------------------------------------
// Edge events, master and slave
// ----------------------------------------
wire m_edge  = gen_run_r & (div_r == 7'h01);
wire s_rise  = sck_s & ~sck_d_r;
wire s_fall  = ~sck_s & sck_d_r;
// Leading edge depends on idle polarity
wire s_lead  = cpol_in ? s_fall : s_rise;                    // [R24]
wire s_trail = cpol_in ? s_rise : s_fall;
wire lead_ev  = is_master ? (m_edge & ~edge_r[0]) : (slave_sel & s_lead);
wire trail_ev = is_master ? (m_edge & edge_r[0]) : (slave_sel & s_trail);
wire sample_ev = cpha_in ? trail_ev : lead_ev;               // [R24]
wire setup_ev  = cpha_in ? lead_ev : trail_ev;
// Master MISO lags by the synchroniser; delay the sample to match
wire take    = is_master ? pipe_r[1] : (slave_sel & sample_ev);
wire in_bit  = is_master ? miso_s : mosi_s;                  // [R6]
// Master finishes only once clock idles and pipeline drains
wire byte_done = (bit_cnt_r == `BITS_PER_BYTE) &
                 (~is_master | (~gen_run_r & (pipe_r == 2'b00)));

// ----------------------------------------
// Master clock generator
// ----------------------------------------
always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        gen_run_r <= 1'b0;
        div_r     <= 7'h00;
        edge_r    <= 5'h00;
        sck_r     <= 1'b0;
    end else if (mode_fault || !is_master) begin
        gen_run_r <= 1'b0;
        sck_r     <= cpol_in;
    end else if (start) begin
        gen_run_r <= 1'b1;                                   // [R1]
        div_r     <= half;
        edge_r    <= 5'h00;
        sck_r     <= cpol_in;
    end else if (m_edge) begin
        sck_r  <= ~sck_r;
        div_r  <= half;
        edge_r <= edge_r + 5'h01;
        if (edge_r == `EDGES_LAST) begin
            gen_run_r <= 1'b0;                               // [R2]
        end
    end else if (gen_run_r) begin
        div_r <= div_r - 7'h01;
    end else begin
        sck_r <= cpol_in;
    end
end

// ----------------------------------------
// Bit counter, sample pipe, slave reset
// ----------------------------------------
always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        pipe_r    <= 2'b00;
        bit_cnt_r <= 4'h0;
        sck_d_r   <= 1'b0;
        rx_sh_r   <= `BYTE_RESET;
        rx_buf_r  <= `BYTE_RESET;
    end else begin
        sck_d_r <= sck_s;
        if (mode_fault || (!is_master && !slave_sel)) begin
            // Deselect drops any partial byte at once
            pipe_r    <= 2'b00;                              // [R20]
            bit_cnt_r <= 4'h0;
        end else begin
            pipe_r <= {pipe_r[0], is_master & sample_ev};
            if (byte_done) begin
                rx_buf_r  <= rx_sh_r;                        // [R7] [R13]
                bit_cnt_r <= 4'h0;
            end else if (take) begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
                rx_sh_r   <= lsb_first_in ? {in_bit, rx_sh_r[7:1]}
                                          : {rx_sh_r[6:0], in_bit};
            end
        end
    end
end

// ----------------------------------------
// Transmit shift register
// ----------------------------------------
// Separate from the receive side, so a reload loses nothing
always @* begin
    sh_nxt = sh_r;
    if (wr_ok) begin
        sh_nxt = data_wr_byte_in;                            // [R9] [R11]
    end else if (setup_ev && !(cpha_in && first_r)) begin
        sh_nxt = lsb_first_in ? {1'b0, sh_r[7:1]}            // [R16]
                              : {sh_r[6:0], 1'b0};
    end
end

always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        sh_r     <= `BYTE_RESET;
        tx_bit_r <= 1'b0;
        first_r  <= 1'b1;
    end else begin
        sh_r     <= sh_nxt;
        tx_bit_r <= lsb_first_in ? sh_nxt[0] : sh_nxt[7];
        if (wr_ok || byte_done || (!is_master && !slave_sel)) begin
            first_r <= 1'b1;
        end else if (setup_ev) begin
            first_r <= 1'b0;
        end
    end
end

// ----------------------------------------
// Master select bit
// ----------------------------------------
// Fault wins over a same-cycle software set, to avoid contention
always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        master_r <= `FLAG_RESET;
    end else if (mode_fault) begin
        master_r <= 1'b0;                                    // [R21]
    end else if (master_wr_in) begin
        master_r <= master_wr_data_in;
    end
end

// ----------------------------------------
// Done and collision flags
// ----------------------------------------
wire flag_set  = byte_done | mode_fault;                     // [R2] [R10]
wire data_acc  = data_rd_in | data_wr_in;
wire flag_clr  = irq_ack_in | (arm_flag_r & data_acc);       // [R23]
wire write_collision_flag_clr  = arm_write_collision_flag_r & data_acc;

always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        flag_r     <= `FLAG_RESET;
        write_collision_flag_r     <= `FLAG_RESET;
        arm_flag_r <= 1'b0;
        arm_write_collision_flag_r <= 1'b0;
        wake_r     <= 1'b0;
    end else begin
        // Set beats clear in the same cycle
        flag_r <= flag_set | (flag_r & ~flag_clr);           // [R23]
        write_collision_flag_r <= write_collision_flag_set | (write_collision_flag_r & ~write_collision_flag_clr);           // [R22]
        wake_r <= flag_set;                                  // [R18]
        if (status_rd_in) begin
            arm_flag_r <= flag_r;
            arm_write_collision_flag_r <= write_collision_flag_r;
        end else if (data_acc || irq_ack_in) begin
            arm_flag_r <= 1'b0;
            arm_write_collision_flag_r <= 1'b0;
        end
    end
end

// ----------------------------------------
// Pin overrides and outputs
// ----------------------------------------
// Slave select is never driven here; the port owns it
assign pins_override_out = active;                           // [R15] [R4]
assign sck_oe_out  = is_master & sck_dir_in;                 // [R15]
assign mosi_oe_out = is_master & mosi_dir_in;
assign miso_oe_out = slave_sel & miso_dir_in;                // [R8]
assign sck_out     = sck_r;
assign mosi_out    = tx_bit_r;                               // [R6]
assign miso_out    = tx_bit_r;

assign rx_byte_out              = rx_buf_r;
assign transfer_done_flag_out   = flag_r;
assign write_collision_flag_out = write_collision_flag_r;
assign master_select_bit_out    = master_r;
assign busy_out                 = busy_w;
assign irq_out   = flag_r & transfer_irq_enable_in;          // [R3]
assign wake_out  = wake_r;

endmodule // spi_master_slave_port

`default_nettype wire

// File: spi_msp_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Port-level protocol checker
// ------------------------------
module spi_msp_properties (
    input wire logic core_clk_in, rst_n_in, ss_n_in,
    input wire logic serial_enable_bit_in, power_gate_bit_in,
    input wire logic transfer_irq_enable_in, data_wr_in, irq_ack_in,
    input wire logic transfer_done_flag_out, write_collision_flag_out,
    input wire logic busy_out, irq_out, wake_out, pins_override_out,
    input wire logic master_select_bit_out, sck_oe_out, mosi_oe_out,
    input wire logic miso_oe_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Block counts as live only when enabled and powered
    wire logic live = serial_enable_bit_in && !power_gate_bit_in;

    a_irq_follows_flag:
        assert property (irq_out == (transfer_done_flag_out
            && transfer_irq_enable_in)) else $error("irq mismatch");
    a_wake_after_set:
        assert property ($rose(transfer_done_flag_out) |-> wake_out)
            else $error("no wake pulse");
    a_collide_sets_flag:
        assert property (data_wr_in && busy_out |=> write_collision_flag_out)
            else $error("collision not flagged");
    a_disabled_pins_free:
        assert property (!live |-> !pins_override_out && !busy_out
            && !sck_oe_out && !mosi_oe_out) else $error("disabled drives");
    a_slave_no_drive:
        assert property (!master_select_bit_out |-> !sck_oe_out
            && !mosi_oe_out) else $error("slave drives sck or mosi");
    a_master_miso_input:
        assert property (master_select_bit_out |-> !miso_oe_out)
            else $error("master drives miso");
    a_ack_clears_flag:
        assert property (irq_ack_in && transfer_done_flag_out && !busy_out
            |=> !transfer_done_flag_out) else $error("ack kept flag");
    a_master_write_starts:
        assert property (live && master_select_bit_out && data_wr_in
            && !busy_out |=> busy_out) else $error("write did not start");
    a_deselect_miso_off:
        assert property ((ss_n_in && !master_select_bit_out) [*3]
            |-> !miso_oe_out) else $error("miso driven while deselected");

    // Main scenarios reached
    c_master_done: cover property ($rose(transfer_done_flag_out)
        && master_select_bit_out);
    c_collision: cover property ($rose(write_collision_flag_out));
    c_fault: cover property ($fell(master_select_bit_out));
endmodule // spi_msp_properties
`default_nettype wire

// File: spi_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Far-side slave peripheral
// ------------------------------
module spi_peer (
    input  wire logic ss_n_in, sck_in, mosi_in,
    input  wire logic cpol_in, cpha_in, lsb_first_in,
    input  wire logic [7:0] tx_byte_in,
    output var  logic       miso_out = 1'b0,
    output var  logic [7:0] rx_byte_out = 8'h00
);
    logic [7:0] sh;
    logic       lead;
    // Rising edge of this is the sampling edge in every mode
    wire logic samp = sck_in ^ cpol_in ^ cpha_in;

    // Frame opens: first bit presented before any edge
    always @(negedge ss_n_in) begin
        sh = tx_byte_in;
        lead = cpha_in;
        miso_out = lsb_first_in ? sh[0] : sh[7];
    end
    // Setup edge; trailing-phase leading edge only presents
    always @(negedge samp) if (!ss_n_in) begin
        if (!lead)
            sh = lsb_first_in ? sh >> 1 : sh << 1;
        lead = 1'b0;
        miso_out = lsb_first_in ? sh[0] : sh[7];
    end
    // Sampling edge
    always @(posedge samp) if (!ss_n_in)
        rx_byte_out = lsb_first_in ? {mosi_in, rx_byte_out[7:1]}
                                   : {rx_byte_out[6:0], mosi_in};
    // Released line must not look like held data
    always @(posedge ss_n_in) miso_out = ~miso_out;
endmodule // spi_peer
`default_nettype wire

// File: test_spi_master_slave_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_spi_master_slave_port;
    // ------------------------------
    // Stimulus, pins and bookkeeping
    // ------------------------------
    logic core_clk_in = 0, rst_n_in = 0, serial_enable_bit_in = 0;
    logic power_gate_bit_in = 0, transfer_irq_enable_in = 0;
    logic lsb_first_in = 0, cpol_in = 0, cpha_in = 0, double_speed_in = 0;
    logic master_wr_in = 0, master_wr_data_in = 0, data_wr_in = 0;
    logic data_rd_in = 0, status_rd_in = 0, irq_ack_in = 0, ss_n_in = 1;
    logic ss_dir_in = 1, mosi_dir_in = 1, sck_dir_in = 1, miso_dir_in = 1;
    logic bsck = 0, bmosi = 0, p;
    logic [1:0] rate_sel_in = 0;
    logic [7:0] data_wr_byte_in = 0, peer_tx = 0;
    wire logic sck_out, sck_oe_out, mosi_out, mosi_oe_out, miso_out;
    wire logic miso_oe_out, pins_override_out, transfer_done_flag_out;
    wire logic write_collision_flag_out, master_select_bit_out, busy_out;
    wire logic irq_out, wake_out, peer_miso;
    wire logic [7:0] rx_byte_out, peer_rx;
    // Pin levels resolved from the DUT's output enables
    wire logic sck_in = sck_oe_out ? sck_out : bsck;
    wire logic mosi_in = mosi_oe_out ? mosi_out : bmosi;
    wire logic miso_in = miso_oe_out ? miso_out : peer_miso;
    int n_fail = 0, n_tests = 0, e, t1, t2, c, m;
    int hh [8] = '{2, 8, 32, 64, 1, 4, 16, 32};

    spi_master_slave_port dut (.*);
    spi_peer peer (.ss_n_in(ss_n_in), .sck_in(sck_in), .mosi_in(mosi_in),
        .cpol_in(cpol_in), .cpha_in(cpha_in), .lsb_first_in(lsb_first_in),
        .tx_byte_in(peer_tx), .miso_out(peer_miso), .rx_byte_out(peer_rx));

    always #10 core_clk_in = ~core_clk_in;

    // ------------------------------
    // Shared tasks
    // ------------------------------
    task chk(input logic [7:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    task wr(input logic [7:0] b);
        data_wr_byte_in = b;
        data_wr_in = 1;
        tick(1);
        data_wr_in = 0;
    endtask
    task set_master(input logic v);
        master_wr_data_in = v;
        master_wr_in = 1;
        tick(1);
        master_wr_in = 0;
    endtask
    task clr;
        status_rd_in = 1;
        tick(1);
        status_rd_in = 0;
        data_rd_in = 1;
        tick(1);
        data_rd_in = 0;
        tick(1);
    endtask
    // Bounded wait for the done flag, counting SCK toggles on the way
    task wait_done;
        e = 0;
        c = 0;
        p = sck_out;
        while (transfer_done_flag_out !== 1'b1 && c < 3000) begin
            tick(1);
            c++;
            if (sck_out !== p) begin
                e++;
                if (e == 1) t1 = c;
                if (e == 2) t2 = c;
            end
            p = sck_out;
        end
        chk(c < 3000, 1);
    endtask
    // Bench as external master in the current mode, SCK period of
    // 160 ns, eight core cycles, inside the quarter-clock limit
    // MOSI moves on the setup edge only, never beside a sample edge
    task bang(input logic [7:0] b, input int nb, output logic [7:0] got);
        for (int k = 7; k > 7 - nb; k--) begin
            if (!cpha_in) bmosi = b[k];
            tick(4);
            bsck = ~bsck;
            if (cpha_in) bmosi = b[k];
            if (!cpha_in) got = {got[6:0], miso_in};
            tick(4);
            bsck = ~bsck;
            if (cpha_in) got = {got[6:0], miso_in};
        end
        tick(6);
    endtask

    // ------------------------------
    // Scenarios
    // ------------------------------
    task t_slave;
        logic [7:0] g;
        transfer_irq_enable_in = 1;
        wr(8'hC3);
        bang(8'hFF, 8, g);
        chk(miso_oe_out, 0);
        chk(transfer_done_flag_out, 0);
        ss_n_in = 0;
        tick(4);
        chk(miso_oe_out, 1);
        bang(8'h5A, 8, g);
        chk(g, 8'hC3);
        chk(rx_byte_out, 8'h5A);
        chk(transfer_done_flag_out, 1);
        chk(irq_out, 1);
        wr(8'h0F);
        chk(rx_byte_out, 8'h5A);
        irq_ack_in = 1;
        tick(1);
        irq_ack_in = 0;
        tick(1);
        chk(transfer_done_flag_out, 0);
        ss_n_in = 1;
        tick(4);
        chk(miso_oe_out, 0);
    endtask
    task t_abort;
        logic [7:0] g;
        ss_n_in = 0;
        tick(4);
        bang(8'hE0, 3, g);
        ss_n_in = 1;
        tick(4);
        chk(transfer_done_flag_out, 0);
        ss_n_in = 0;
        tick(4);
        bang(8'h81, 8, g);
        chk(rx_byte_out, 8'h81);
        clr;
        ss_n_in = 1;
    endtask
    // Slave in mode 3, LSB first; SCK idles high before select
    task t_slave3;
        logic [7:0] g;
        tick(4);
        {lsb_first_in, cpha_in, cpol_in} = 3'h7;
        bsck = 1;
        wr(8'h0D);
        tick(4);
        ss_n_in = 0;
        tick(4);
        bang(8'h1E, 8, g);
        chk(g, 8'hB0);
        chk(rx_byte_out, 8'h78);
        clr;
        ss_n_in = 1;
        tick(4);
        {lsb_first_in, cpha_in, cpol_in} = 3'h0;
        bsck = 0;
    endtask
    task t_master(input int k);
        logic [7:0] b;
        b = 8'hA5 ^ k[7:0];
        {double_speed_in, rate_sel_in} = k[2:0];
        {lsb_first_in, cpha_in, cpol_in} = k[2:0];
        transfer_irq_enable_in = k[0];
        peer_tx = ~b;
        tick(3);
        ss_n_in = 0;
        wr(b);
        wait_done;
        chk(wake_out, 1);
        chk(e, 16);
        chk(t2 - t1, hh[k]);
        chk(sck_out, cpol_in);
        chk(peer_rx, b);
        chk(rx_byte_out, ~b);
        chk(irq_out, k[0]);
        clr;
        chk(transfer_done_flag_out, 0);
        ss_n_in = 1;
    endtask
    task t_collide;
        {double_speed_in, rate_sel_in} = 3'h1;
        {lsb_first_in, cpha_in, cpol_in} = 3'h0;
        // Let SCK settle at its new idle level before the frame
        tick(3);
        ss_n_in = 0;
        wr(8'h96);
        tick(20);
        wr(8'h11);
        tick(1);
        chk(write_collision_flag_out, 1);
        wait_done;
        chk(peer_rx, 8'h96);
        clr;
        chk(write_collision_flag_out, 0);
        ss_n_in = 1;
    endtask
    task t_fault;
        // Synced select must read high before the pin becomes an input
        tick(4);
        ss_dir_in = 0;
        tick(4);
        chk(master_select_bit_out, 1);
        ss_n_in = 0;
        tick(4);
        chk(master_select_bit_out, 0);
        chk(transfer_done_flag_out, 1);
        chk(sck_oe_out, 0);
        chk(mosi_oe_out, 0);
        clr;
        ss_n_in = 1;
        ss_dir_in = 1;
    endtask
    task t_off;
        set_master(1);
        serial_enable_bit_in = 0;
        wr(8'h42);
        tick(2);
        chk(busy_out, 0);
        chk(pins_override_out, 0);
        serial_enable_bit_in = 1;
        power_gate_bit_in = 1;
        wr(8'h24);
        tick(2);
        chk(busy_out, 0);
        chk(pins_override_out, 0);
        power_gate_bit_in = 0;
    endtask

    // Main sequence; reset held for four cycles
    initial begin
        tick(4);
        rst_n_in = 1;
        tick(4);
        serial_enable_bit_in = 1;
        tick(4);
        t_slave;
        $display("slave test done");
        t_abort;
        $display("abort test done");
        t_slave3;
        $display("slave mode 3 test done");
        set_master(1);
        for (m = 0; m < 8; m++)
            t_master(m);
        $display("master tests done");
        t_collide;
        $display("collision test done");
        t_fault;
        $display("fault test done");
        t_off;
        $display("disable test done");
        give_verdict;
    end
    // Watchdog at 20000 cycles, about six times the expected run
    initial begin
        #400000;
        n_fail++;
        give_verdict;
    end
endmodule // test_spi_master_slave_port

bind spi_master_slave_port spi_msp_properties chk_i (.*);
`default_nettype wire
